/* hdl/dgp_pkg.sv */
// Package for the dual GPIO port block: register offsets, field layout,
// reset values and the bus carrier struct.
// Assumes an 8-bit CPU register bus with a one-cycle read latency.
package dgp_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] DGP_OFF_F_LATCH  = 3'h0;
  localparam logic [2:0] DGP_OFF_F_DIR    = 3'h1;
  localparam logic [2:0] DGP_OFF_G_LATCH  = 3'h2;
  localparam logic [2:0] DGP_OFF_G_DIR    = 3'h3;
  localparam logic [2:0] DGP_OFF_G_PULLUP = 3'h4;
  localparam logic [2:0] DGP_OFF_STANDBY  = 3'h5;

  // Implemented bits of each port register
  localparam logic [7:0] DGP_F_MASK = 8'h07;
  localparam logic [7:0] DGP_G_MASK = 8'h06;

  // Field positions
  localparam int DGP_F_LSB   = 0;
  localparam int DGP_G_LSB   = 1;
  localparam int DGP_SPL_BIT = 0;

  // Values after reset
  localparam logic [7:0] DGP_DIR_RST   = 8'h00;
  localparam logic [7:0] DGP_LATCH_RST = 8'h00;
  localparam logic [7:0] DGP_PULL_RST  = 8'h00;
  localparam logic       DGP_SPL_RST   = 1'b0;

  // Register bus request carrier
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       rmw;
  } dgp_req_s;

endpackage : dgp_pkg

/* hdl/dgp_port_logic.sv */
// Two small GPIO ports: a three-pin first port and a two-pin second port
// with pull-ups, behind an 8-bit register port.
// Assumes pin inputs are synchronous to clk_sys; the pad resolves the wire
// from pin_out / pin_oe / pullup_on.
`timescale 1ns/1ps

module dgp_port_logic #(
  parameter logic [2:0] F_OPEN_DRAIN = 3'h0, // Per-pin open-drain option
  parameter bit         F2_IS_RESET  = 1'b0  // Third pin is reset input
) (
  input  wire logic            clk_sys,
  input  wire logic            reset_n,
  input  wire dgp_pkg::dgp_req_s req,
  output logic [7:0]           rdata,
  input  wire logic            standby_enter,
  input  wire logic [2:0]      f_pin_in,
  output logic [2:0]           f_pin_out,
  output logic [2:0]           f_pin_oe,
  output logic [2:0]           f_pin_in_gated,
  input  wire logic [1:0]      g_pin_in,
  output logic [1:0]           g_pin_out,
  output logic [1:0]           g_pin_oe,
  output logic [1:0]           g_pullup_on,
  output logic [1:0]           g_pin_in_gated
);
  import dgp_pkg::*;

  logic [2:0] f_latch_q;
  logic [2:0] f_dir_q;
  logic [1:0] g_latch_q;
  logic [1:0] g_dir_q;
  logic [1:0] g_pull_q;
  logic       spl_q;
  logic       hiz_q;
  logic [2:0] f_gp;
  logic [2:0] f_out_d;
  logic [2:0] f_oe_d;
  logic [1:0] g_out_d;
  logic [1:0] g_oe_d;
  logic [7:0] rdata_d;
  logic [7:0] f_read;
  logic [7:0] g_read;

  // A reset-pin part removes the third pin from port use
  assign f_gp = F2_IS_RESET ? 3'h3 : 3'h7;

  // Latches keep only implemented bits; writes land whatever the direction
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      f_latch_q <= DGP_LATCH_RST[2:0];
      g_latch_q <= DGP_LATCH_RST[1:0];
    end else if (req.wr) begin
      if (req.addr == DGP_OFF_F_LATCH)
        f_latch_q <= req.wdata[DGP_F_LSB +: 3];
      if (req.addr == DGP_OFF_G_LATCH)
        g_latch_q <= req.wdata[DGP_G_LSB +: 2];
    end
  end

  // Direction registers clear on reset so no pin drives early
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      f_dir_q <= DGP_DIR_RST[2:0];
      g_dir_q <= DGP_DIR_RST[1:0];
    end else if (req.wr) begin
      if (req.addr == DGP_OFF_F_DIR)
        f_dir_q <= req.wdata[DGP_F_LSB +: 3] & f_gp;
      if (req.addr == DGP_OFF_G_DIR)
        g_dir_q <= req.wdata[DGP_G_LSB +: 2];
    end
  end

  // Pull-up and standby pin-state controls
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      g_pull_q <= DGP_PULL_RST[1:0];
      spl_q    <= DGP_SPL_RST;
    end else if (req.wr) begin
      if (req.addr == DGP_OFF_G_PULLUP)
        g_pull_q <= req.wdata[DGP_G_LSB +: 2];
      if (req.addr == DGP_OFF_STANDBY)
        spl_q <= req.wdata[DGP_SPL_BIT];
    end
  end

  // Float state follows standby level; bit clear keeps pins as they are
  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      hiz_q <= 1'b0;
    else
      hiz_q <= standby_enter & spl_q;
  end

  // Pin drive: latch on outputs, open-drain high releases the pin
  always_comb begin
    f_out_d = f_latch_q & f_dir_q;
    f_oe_d  = f_dir_q & ~(F_OPEN_DRAIN & f_latch_q);
    g_out_d = g_latch_q & g_dir_q;
    g_oe_d  = g_dir_q;
    if (standby_enter & spl_q) begin
      f_oe_d = 3'h0;
      g_oe_d = 2'h0;
    end
  end

  // Registered pin outputs, one cycle after the controlling register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      f_pin_out   <= 3'h0;
      f_pin_oe    <= 3'h0;
      g_pin_out   <= 2'h0;
      g_pin_oe    <= 2'h0;
      g_pullup_on <= 2'h0;
    end else begin
      f_pin_out   <= f_out_d;
      f_pin_oe    <= f_oe_d;
      g_pin_out   <= g_out_d;
      g_pin_oe    <= g_oe_d;
      // Never fight a driven low; off in forced float too
      g_pullup_on <= g_pull_q & ~(g_oe_d & ~g_out_d)
                     & {2{~(standby_enter & spl_q)}};
    end
  end

  // Input path forced low while floating, to stop leakage
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      f_pin_in_gated <= 3'h0;
      g_pin_in_gated <= 2'h0;
    end else begin
      f_pin_in_gated <= (standby_enter & spl_q) ? 3'h0 : f_pin_in & f_gp;
      g_pin_in_gated <= (standby_enter & spl_q) ? 2'h0 : g_pin_in;
    end
  end

  // Read mux: pin level for inputs, latch for outputs or RMW reads
  always_comb begin
    f_read = 8'h00;
    g_read = 8'h00;
    f_read[DGP_F_LSB +: 3] = ((f_dir_q | {3{req.rmw}}) & f_latch_q)
                           | (~(f_dir_q | {3{req.rmw}}) & f_pin_in
                              & {3{~hiz_q}}) ;
    f_read = f_read & {5'h00, f_gp};
    g_read[DGP_G_LSB +: 2] = ((g_dir_q | {2{req.rmw}}) & g_latch_q)
                           | (~(g_dir_q | {2{req.rmw}}) & g_pin_in
                              & {2{~hiz_q}});
    case (req.addr)
      DGP_OFF_F_LATCH:  rdata_d = f_read;
      DGP_OFF_F_DIR:    rdata_d = {5'h00, f_dir_q};
      DGP_OFF_G_LATCH:  rdata_d = g_read;
      DGP_OFF_G_DIR:    rdata_d = {5'h00, g_dir_q, 1'b0};
      DGP_OFF_G_PULLUP: rdata_d = {5'h00, g_pull_q, 1'b0};
      DGP_OFF_STANDBY:  rdata_d = {7'h00, spl_q};
      default:          rdata_d = 8'h00;
    endcase
  end

  // Read data stands one cycle after the strobe and reads zero otherwise
  always_ff @(posedge clk_sys) begin
    if (!reset_n)
      rdata <= 8'h00;
    else
      rdata <= req.rd ? rdata_d : 8'h00;
  end

  // Assertions
  a_reset_dir_clear: assert property (@(posedge clk_sys)
    !reset_n |=> (f_dir_q == 3'h0 && g_dir_q == 2'h0 && f_pin_oe == 3'h0))
    else $error("direction not cleared by reset");

  a_standby_float: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (standby_enter && spl_q) |=> (f_pin_oe == 3'h0 && g_pin_oe == 2'h0))
    else $error("pins driven in standby float");

  a_input_locked_low: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (standby_enter && spl_q) |=> (f_pin_in_gated == 3'h0
                                 && g_pin_in_gated == 2'h0))
    else $error("input path not held low");

  a_output_drives: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> ((f_pin_oe & (f_pin_out ^ $past(f_latch_q))) == 3'h0))
    else $error("output pin not at latch value");

  a_input_no_drive: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> ((g_pin_oe & ~$past(g_dir_q)) == 2'h0))
    else $error("input pin driven");

  a_pullup_low_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (g_pullup_on & g_pin_oe & ~g_pin_out) == 2'h0)
    else $error("pull-up on while driving low");

  a_open_drain_hiz: assert property (@(posedge clk_sys) disable iff (!reset_n)
    1'b1 |=> ((f_pin_oe & $past(F_OPEN_DRAIN & f_latch_q)) == 3'h0))
    else $error("open-drain pin driven high");

  a_rmw_reads_latch: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (req.rd && req.rmw && req.addr == DGP_OFF_G_LATCH)
      |=> rdata == {5'h00, $past(g_latch_q), 1'b0})
    else $error("rmw read did not return latch");

  a_unused_read_zero: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
    (rdata & 8'hF8) == 8'h00)
    else $error("unimplemented bits read nonzero");

  a_standby_keep: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (standby_enter && !spl_q && $stable(spl_q)
      && $stable({f_dir_q, f_latch_q, g_dir_q}))
      |=> $stable({f_pin_oe, g_pin_oe}))
    else $error("pins changed in retained standby");

  // Named steps of standby entry and wake
  sequence s_float_req;
    standby_enter && spl_q;
  endsequence
  sequence s_wake;
    !standby_enter;
  endsequence

  // Latch write lands whatever the direction
  a_f_latch_write: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.wr && req.addr == DGP_OFF_F_LATCH)
      |=> f_latch_q == $past(req.wdata[2:0]))
    else $error("first latch write lost");

  // Second latch keeps only bits 2 and 1
  a_g_latch_write: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.wr && req.addr == DGP_OFF_G_LATCH)
      |=> g_latch_q == $past(req.wdata[2:1]))
    else $error("second latch write lost");

  // Direction write lands unless pin 2 is the reset input
  a_f_dir_write: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.wr && req.addr == DGP_OFF_F_DIR
      && !F2_IS_RESET) |=> f_dir_q == $past(req.wdata[2:0]))
    else $error("first direction write lost");

  // Second direction keeps only bits 2 and 1
  a_g_dir_write: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.wr && req.addr == DGP_OFF_G_DIR)
      |=> g_dir_q == $past(req.wdata[2:1]))
    else $error("second direction write lost");

  // Pull-up bits follow their writes
  a_pull_write: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.wr && req.addr == DGP_OFF_G_PULLUP)
      |=> g_pull_q == $past(req.wdata[2:1]))
    else $error("pull-up write lost");

  // Reset-pin option never lets pin 2 act as a port
  a_reset_pin_quiet: assert property (@(posedge clk_sys)
    disable iff (!reset_n) F2_IS_RESET |-> (!f_dir_q[2] && !f_pin_oe[2]
      && !f_pin_in_gated[2]))
    else $error("reset pin acting as port");

  // Input pins of the first port never drive
  a_f_oe_needs_dir: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
      1'b1 |=> ((f_pin_oe & ~$past(f_dir_q)) == 3'h0))
    else $error("first-port input pin driven");

  // Outside forced float the second port follows its direction bits
  a_g_dir_drives: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
      !(standby_enter && spl_q) |=> g_pin_oe == $past(g_dir_q))
    else $error("second-port output pin not driven");

  // Driven second-port pins show the latch
  a_g_out_value: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
      1'b1 |=> ((g_pin_oe & (g_pin_out ^ $past(g_latch_q))) == 2'h0))
    else $error("second-port pin not at latch value");

  // No pull-up without its bit
  a_pullup_needs_bit: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
      1'b1 |=> ((g_pullup_on & ~$past(g_pull_q)) == 2'h0))
    else $error("pull-up on with bit clear");

  // Input pins with the bit set get their pull-up
  a_pullup_on_input: assert property (@(posedge clk_sys)
    disable iff (!reset_n) !(standby_enter && spl_q)
      |=> (($past(g_pull_q & ~g_dir_q) & ~g_pullup_on) == 2'h0))
    else $error("pull-up missing on input pin");

  // Forced float drops the pull-ups too
  a_pullup_float_off: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
      s_float_req |=> g_pullup_on == 2'h0)
    else $error("pull-up on in forced float");

  // Output pins read back the latch
  a_f_read_output: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.rd && req.addr == DGP_OFF_F_LATCH)
      |=> (((rdata[2:0] ^ $past(f_latch_q)) & $past(f_dir_q)) == 3'h0))
    else $error("output pin read not latch");

  // RMW reads of the first port return the latch
  a_f_read_rmw: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.rd && req.rmw && !F2_IS_RESET
      && req.addr == DGP_OFF_F_LATCH) |=> rdata[2:0] == $past(f_latch_q))
    else $error("first-port rmw read not latch");

  // Plain reads of first-port inputs return the pin level
  a_f_read_input: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.rd && !req.rmw && !hiz_q
      && req.addr == DGP_OFF_F_LATCH) |=> (((rdata[2:0] ^ $past(f_pin_in))
      & ~$past(f_dir_q) & {~F2_IS_RESET, 2'b11}) == 3'h0))
    else $error("first-port input read not pin");

  // Plain reads of second-port inputs return the pin level
  a_g_read_input: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.rd && !req.rmw && !hiz_q
      && req.addr == DGP_OFF_G_LATCH) |=> (((rdata[2:1] ^ $past(g_pin_in))
      & ~$past(g_dir_q)) == 2'h0))
    else $error("second-port input read not pin");

  // Read data stands only after a read strobe
  a_read_idle_zero: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
      !req.rd |=> rdata == 8'h00)
    else $error("read data without strobe");

  // First direction reads back in bits 2..0
  a_f_dir_read: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.rd && req.addr == DGP_OFF_F_DIR)
      |=> rdata == {5'h00, $past(f_dir_q)})
    else $error("first direction read wrong");

  // Second direction reads back in bits 2..1
  a_g_dir_read: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.rd && req.addr == DGP_OFF_G_DIR)
      |=> rdata == {5'h00, $past(g_dir_q), 1'b0})
    else $error("second direction read wrong");

  // Unmapped offsets read zero
  a_unmapped_read: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.rd && req.addr > DGP_OFF_STANDBY)
      |=> rdata == 8'h00)
    else $error("unmapped offset read nonzero");

  // Pin-state bit reads back in bit 0
  a_spl_read: assert property (@(posedge clk_sys)
    disable iff (!reset_n) (req.rd && req.addr == DGP_OFF_STANDBY)
      |=> rdata == {7'h00, $past(spl_q)})
    else $error("pin-state bit read wrong");

  // Wake from forced float gives the second-port pins back to their direction
  a_float_release: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
      s_float_req ##1 s_wake |=> g_pin_oe == $past(g_dir_q))
    else $error("pins not released after wake");

  // Read path sees the float state one cycle on
  a_hiz_tracks: assert property (@(posedge clk_sys)
    disable iff (!reset_n)
      s_float_req |=> hiz_q)
    else $error("float state not tracked");

endmodule : dgp_port_logic

/* verification/dgp_pin_model.sv */
// Pad model: resolves each pin from device drive, pull-up and an
// external source that the bench controls.
`timescale 1ns/1ps
module dgp_pin_model (
  input  wire logic       clk_sys,
  input  wire logic [2:0] f_out,
  input  wire logic [2:0] f_oe,
  input  wire logic [1:0] g_out,
  input  wire logic [1:0] g_oe,
  input  wire logic [1:0] g_pull,
  input  wire logic [4:0] ext_val,
  input  wire logic [4:0] ext_en,
  output logic [2:0]      f_in,
  output logic [1:0]      g_in
);
  logic [4:0] float_q = 5'h0A;
  // Floating pads flip every cycle so no stale level passes as valid
  always_ff @(posedge clk_sys) begin
    float_q <= ~float_q;
  end
  // Device drive wins, then external source, then pull-up
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      f_in[i] = f_oe[i] ? f_out[i] : ext_en[i] ? ext_val[i] : float_q[i];
    end
    for (int i = 0; i < 2; i++) begin
      g_in[i] = g_oe[i] ? g_out[i] : ext_en[i+3] ? ext_val[i+3] :
                g_pull[i] ? 1'b1 : float_q[i+3];
    end
  end
endmodule : dgp_pin_model

/* verification/dual_gpio_port_logic_tb.sv */
// Bench for the dual GPIO port: register tasks, pin and standby checks.
// Assumes the pad model closes the pin loop; one 25 MHz clock.
`timescale 1ns/1ps
module dual_gpio_port_logic_tb;
  import dgp_pkg::*;
  logic       clk_sys;
  logic       reset_n;
  dgp_req_s   req;
  logic [7:0] rdata;
  logic       standby_enter;
  logic [2:0] f_in, f_out, f_oe, f_gated;
  logic [1:0] g_in, g_out, g_oe, g_pull, g_gated;
  logic [4:0] ext_val, ext_en;
  int         n_mismatch = 0;
  int         checked = 0;
  int         cycles = 0;
  // Pin 0 open-drain so its high level must float
  dgp_port_logic #(.F_OPEN_DRAIN(3'h1), .F2_IS_RESET(1'b0)) dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .req(req), .rdata(rdata),
    .standby_enter(standby_enter), .f_pin_in(f_in), .f_pin_out(f_out),
    .f_pin_oe(f_oe), .f_pin_in_gated(f_gated), .g_pin_in(g_in),
    .g_pin_out(g_out), .g_pin_oe(g_oe), .g_pullup_on(g_pull),
    .g_pin_in_gated(g_gated));
  dgp_pin_model pin_u (.clk_sys(clk_sys), .f_out(f_out), .f_oe(f_oe),
    .g_out(g_out), .g_oe(g_oe), .g_pull(g_pull), .ext_val(ext_val),
    .ext_en(ext_en), .f_in(f_in), .g_in(g_in));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // Hang guard, far above the roughly 60 cycles needed
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{a, d, 1'b1, 1'b0, 1'b0};
    @(posedge clk_sys);
    req <= '0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic m, input logic [7:0] e);
    @(posedge clk_sys);
    req <= '{a, 8'h00, 1'b0, 1'b1, m};
    @(posedge clk_sys);
    req <= '0;
    #1 chk(rdata, e);
  endtask : rd
  // Pins follow registers one cycle later
  task automatic settle;
    @(posedge clk_sys);
    #1;
  endtask : settle
  initial begin
    reset_n = 1'b0;
    req = '0;
    standby_enter = 1'b0;
    ext_val = 5'h00;
    ext_en = 5'h1F;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(DGP_OFF_F_DIR, 1'b0, 8'h00);
    rd(DGP_OFF_G_DIR, 1'b0, 8'h00);
    wr(DGP_OFF_F_LATCH, 8'hFD);
    settle();
    chk({3'h0, f_oe, g_oe}, 8'h00);
    wr(DGP_OFF_F_DIR, 8'hFF);
    settle();
    chk({5'h0, f_oe}, 8'h06);
    chk({5'h0, f_out & f_oe}, 8'h04);
    rd(DGP_OFF_F_LATCH, 1'b0, 8'h05);
    rd(DGP_OFF_F_DIR, 1'b0, 8'h07);
    ext_val <= 5'h02;
    wr(DGP_OFF_F_DIR, 8'h00);
    settle();
    rd(DGP_OFF_F_LATCH, 1'b0, 8'h02);
    rd(DGP_OFF_F_LATCH, 1'b1, 8'h05);
    wr(DGP_OFF_G_LATCH, 8'hFB);
    wr(DGP_OFF_G_PULLUP, 8'h06);
    wr(DGP_OFF_G_DIR, 8'h06);
    settle();
    chk({4'h0, g_oe, g_out}, 8'h0D);
    chk({6'h0, g_pull}, 8'h01);
    rd(DGP_OFF_G_LATCH, 1'b0, 8'h02);
    // Peripheral input use: release pads, direction cleared
    ext_en <= 5'h07;
    wr(DGP_OFF_G_DIR, 8'h00);
    settle();
    chk({6'h0, g_pull}, 8'h03);
    rd(DGP_OFF_G_LATCH, 1'b0, 8'h06);
    wr(DGP_OFF_G_PULLUP, 8'h00);
    settle();
    chk({6'h0, g_pull}, 8'h00);
    standby_enter <= 1'b1;
    wr(DGP_OFF_F_DIR, 8'h07);
    settle();
    chk({5'h0, f_oe}, 8'h06);
    wr(DGP_OFF_STANDBY, 8'h01);
    settle();
    chk({1'b0, f_oe, g_oe, g_pull, 1'b0}, 8'h00);
    chk({3'h0, f_gated, g_gated}, 8'h00);
    standby_enter <= 1'b0;
    settle();
    settle();
    chk({5'h0, f_oe}, 8'h06);
    chk({5'h0, f_gated}, 8'h04);
    wr(3'h6, 8'hFF);
    rd(3'h7, 1'b0, 8'h00);
    rd(DGP_OFF_F_LATCH, 1'b0, 8'h05);
    tally_and_finish();
  end
endmodule : dual_gpio_port_logic_tb
